// *** dv/sfpi_chk.sv ***
// Port checker for the serial flash pin front end, bound to its top
`timescale 1ns/1ps
module sfpi_chk (
   // System
   input wire logic clk,
   input wire logic rst,
   // Link pins
   input wire logic cs_n,
   input wire logic hold_n,
   input wire logic wp_n,
   input wire logic dual_lane_zero_oe_n,
   input wire logic dual_lane_one_oe_n,
   // Receive side
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_ready,
   // Device state
   input wire logic busy,
   input wire logic prot_armed,
   input wire logic selected,
   input wire logic standby,
   input wire logic paused,
   input wire logic hw_lock,
   input wire logic frame_start,
   input wire logic frame_end
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_desel;
      cs_n [*2];
   endsequence
   sequence s_open;
      $fell(cs_n);
   endsequence
   sequence s_close;
      $rose(cs_n);
   endsequence
   chk_desel_float: assert property (
      s_desel |-> dual_lane_one_oe_n && dual_lane_zero_oe_n)
      else $error("lane driven while deselected");
   chk_frame_open: assert property (s_open |-> ##[1:4] frame_start)
      else $error("no frame start after select fall");
   chk_frame_close: assert property (s_close |-> ##[1:4] frame_end)
      else $error("no frame end after select rise");
   chk_busy_standby: assert property (busy |-> !standby)
      else $error("standby while internal cycle runs");
   chk_sel_active: assert property (
      (!cs_n) [*4] |-> selected && !standby)
      else $error("select not seen");
   chk_desel_quiet: assert property (
      cs_n [*8] ##0 !rx_valid |=> !rx_valid)
      else $error("byte taken while deselected");
   chk_rx_hold: assert property (
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
      else $error("received byte changed before drain");
   chk_dual_pair: assert property (
      !dual_lane_zero_oe_n |-> !dual_lane_one_oe_n && !cs_n)
      else $error("lane zero driven alone");
   chk_lock_on: assert property (
      (!wp_n && prot_armed) [*4] |-> hw_lock)
      else $error("locking not engaged");
   chk_lock_off: assert property (wp_n [*4] |-> !hw_lock)
      else $error("locking with protect high");
   chk_pause_float: assert property (
      !hold_n |-> dual_lane_one_oe_n)
      else $error("lane one driven while paused");
   chk_pause_seen: assert property (
      $fell(hold_n) && !cs_n |-> ##[1:4] paused)
      else $error("pause not reported");
endmodule : sfpi_chk
bind sfpi_core sfpi_chk i_chk (.clk, .rst, .cs_n, .hold_n, .wp_n,
   .dual_lane_zero_oe_n, .dual_lane_one_oe_n, .rx_data, .rx_valid,
   .rx_ready, .busy, .prot_armed, .selected, .standby, .paused,
   .hw_lock, .frame_start, .frame_end);

// *** dv/sfpi_host.sv ***
// Host SPI master model, mode 0, link clock still outside frames
`timescale 1ns/1ps
module sfpi_host (
   // Link pins
   output logic cs_n,
   output logic sck,
   output logic hold_n,
   // Lane zero drive, released when hz_en low
   output logic hz,
   output logic hz_en,
   // Lane levels at the pins
   input wire logic lz,
   input wire logic lo
);
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      hold_n = 1'b1;
      hz = 1'b0;
      hz_en = 1'b1;
   end
   task automatic frame(input logic open);
      #7;
      cs_n = ~open;
      #7;
   endtask : frame
   // one bit driven per clock, two read per clock when dual, MSB first
   task automatic shift(input logic [7:0] v, input int n,
                        input logic dual, output logic [7:0] r);
      r = 8'h00;
      hz_en = ~dual;
      for (int i = 7; i > 7 - n; i--) begin
         hz = v[i];
         #6;
         sck = 1'b1;
         r = dual ? {r[5:0], lo, lz} : {r[6:0], lo};
         #6;
         sck = 1'b0;
      end
      // Drive left as set; next shift picks it, no double write
   endtask : shift
   // pause only selected with clock low
   task automatic pause(input int n);
      #3;
      hold_n = 1'b0;
      repeat (n) begin
         hz = ~hz;
         #6;
         sck = 1'b1;
         #6;
         sck = 1'b0;
      end
      #3;
      hold_n = 1'b1;
   endtask : pause
   // Input line moves with clock still
   task automatic wiggle(input int n);
      repeat (n) begin
         #5;
         hz = ~hz;
      end
   endtask : wiggle
endmodule : sfpi_host

// *** dv/sfpi_tb_top.sv ***
// Self-checking bench for the serial flash pin front end
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   fails++; $display("ERROR %s exp %h got %h", nm, (e), (g)); end end
module sfpi_tb_top;
   logic clk = 1'b0, rst = 1'b1, wp_n = 1'b1, prot_armed = 1'b0;
   logic busy = 1'b0, rx_ready = 1'b0, tx_dual = 1'b0, tx_valid = 1'b0;
   logic [7:0] tx_data = 8'h00, rx_data, r, c0, m, d, t1, t2;
   wire cs_n, sck, hold_n, hz, hz_en, lz, lo;
   logic out0, oe0_n, out1, oe1_n, rx_valid, rx_overrun, tx_ready;
   logic selected, standby, paused, hw_lock, frame_start, frame_end;
   logic [7:0] exp_q[$];
   int fails = 0, total_checks = 0, seed = 1239;
   int n_frames = 0, n_open = 0, n_close = 0, n_pause = 0;
   always #12.5 clk = ~clk;
   // Pulses last one clock, so each spans exactly one falling edge
   always @(negedge clk) begin
      if (frame_start === 1'b1) n_open++;
      if (frame_end === 1'b1) n_close++;
      if (paused === 1'b1) n_pause++;
   end
   // Released lane one shows the inverse of its last value; lane zero shows hz, inverted while hz_en is low
   assign lz = !oe0_n ? out0 : hz_en ? hz : ~hz;
   assign lo = !oe1_n ? out1 : ~out1;
   sfpi_host i_host (.cs_n(cs_n), .sck(sck), .hold_n(hold_n), .hz(hz),
      .hz_en(hz_en), .lz(lz), .lo(lo));
   sfpi_core i_dut (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck),
      .wp_n(wp_n), .hold_n(hold_n), .dual_lane_zero_in(lz),
      .dual_lane_zero_out(out0), .dual_lane_zero_oe_n(oe0_n),
      .dual_lane_one_out(out1), .dual_lane_one_oe_n(oe1_n),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_overrun(rx_overrun), .tx_data(tx_data), .tx_dual(tx_dual),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy),
      .prot_armed(prot_armed), .selected(selected), .standby(standby),
      .paused(paused), .hw_lock(hw_lock), .frame_start(frame_start),
      .frame_end(frame_end));
   task automatic summarize();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : summarize
   task automatic tmo(input string nm);
      fails++;
      $display("ERROR timeout %s", nm);
      summarize();
   endtask : tmo
   task automatic push(input logic [7:0] v, input logic dl);
      @(negedge clk);
      for (int i = 0; i < 99 && tx_ready !== 1'b1; i++) @(negedge clk);
      if (tx_ready !== 1'b1) tmo("tx_ready");
      tx_data = v;
      tx_dual = dl;
      tx_valid = 1'b1;
      @(negedge clk);
      tx_valid = 1'b0;
   endtask : push
   task automatic drain(input int n);
      logic [7:0] e;
      for (int k = 0; k < n; k++) begin
         for (int i = 0; i < 60 && rx_valid !== 1'b1; i++) @(negedge clk);
         if (rx_valid !== 1'b1) tmo("rx_valid");
         e = exp_q.pop_front();
         `CHK("rx_data", e, rx_data)
         rx_ready = 1'b1;
         @(negedge clk);
         rx_ready = 1'b0;
         @(negedge clk);
      end
   endtask : drain
   task automatic open_frame();
      n_frames++;
      i_host.frame(1'b1);
      for (int i = 0; i < 20 && selected !== 1'b1; i++) @(negedge clk);
      if (selected !== 1'b1) tmo("selected");
   endtask : open_frame
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      `CHK("lane_one_oe_n", 1'b1, oe1_n)
      for (int c = 0; c < 4; c++) begin
         wp_n = c[0];
         prot_armed = c[1];
         repeat (4) @(negedge clk);
         `CHK("hw_lock", ~c[0] & c[1], hw_lock)
      end
      busy = 1'b1;
      @(negedge clk);
      `CHK("standby", 1'b0, standby)
      busy = 1'b0;
      i_host.wiggle(9);
      repeat (8) @(negedge clk);
      `CHK("rx_valid", 1'b0, rx_valid)
      $display("test status done");
      for (int f = 0; f < 4; f++) begin
         {c0, m, d, t1} = $random(seed);
         t2 = $random(seed);
         {busy, wp_n, prot_armed} = t2[2:0];
         open_frame();
         `CHK("standby", 1'b0, standby)
         push(t1, 1'b0);
         if (f == 0) begin
            i_host.shift(c0, 4, 1'b0, r);
            i_host.pause(3);
            i_host.shift(c0 << 4, 4, 1'b0, r);
         end else begin
            i_host.shift(c0, 8, 1'b0, r);
         end
         i_host.shift(m, 8, 1'b0, r);
         `CHK("single_read", t1, r)
         push(t2, 1'b1);
         i_host.shift(d, 8, 1'b0, r);
         i_host.shift(8'h00, 4, 1'b1, r);
         `CHK("dual_read", t2, r)
         i_host.frame(1'b0);
         exp_q.push_back(c0);
         exp_q.push_back(m);
         exp_q.push_back(d);
         drain(3);
         `CHK("standby", ~busy, standby)
         `CHK("hw_lock", ~wp_n & prot_armed, hw_lock)
      end
      $display("test frames done");
      open_frame();
      for (int k = 0; k < 18; k++) begin
         d = $random(seed);
         exp_q.push_back(d);
         i_host.shift(d, 8, 1'b0, r);
      end
      i_host.frame(1'b0);
      d = exp_q.pop_back();
      repeat (20) @(negedge clk);
      `CHK("rx_overrun", 1'b1, rx_overrun)
      drain(17);
      open_frame();
      i_host.shift(8'h5a, 5, 1'b0, r);
      i_host.frame(1'b0);
      repeat (20) @(negedge clk);
      `CHK("rx_overrun", 1'b0, rx_overrun)
      `CHK("rx_valid", 1'b0, rx_valid)
      `CHK("frame_start", n_frames, n_open)
      `CHK("frame_end", n_frames, n_close)
      `CHK("paused", 1'b1, n_pause > 0)
      $display("test buffer done");
      summarize();
   end
endmodule : sfpi_tb_top

// *** logic/sfpi_core.sv ***
// Serial flash pin front end: link shifters, crossings, receive FIFO
`timescale 1ns/1ps
module sfpi_core (
   // System clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link pins from the host
   input wire logic cs_n,
   input wire logic sck,
   input wire logic wp_n,
   input wire logic hold_n,
   // Lane zero: serial input, output during dual reads
   input wire logic dual_lane_zero_in,
   output logic dual_lane_zero_out,
   output logic dual_lane_zero_oe_n,
   // Lane one: serial output
   output logic dual_lane_one_out,
   output logic dual_lane_one_oe_n,
   // Received command, address and write bytes
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic rx_overrun,
   // Read data to send, with lane mode per byte
   input wire logic [7:0] tx_data,
   input wire logic tx_dual,
   input wire logic tx_valid,
   output logic tx_ready,
   // Device state
   input wire logic busy,
   input wire logic prot_armed,
   output logic selected,
   output logic standby,
   output logic paused,
   output logic hw_lock,
   output logic frame_start,
   output logic frame_end
);
   // Frame-scoped link state is cleared whenever select is high
   logic frame_rst;
   assign frame_rst = rst | cs_n;

   // ---------------- Link, rising edge: sampling ----------------
   typedef struct packed {
      logic [sfpi_pkg::CNT_W-1:0] bit_cnt;
      logic [sfpi_pkg::BYTE_W-2:0] shift;
   } sfpi_rise_t;

   typedef struct packed {
      logic tog;
      logic [sfpi_pkg::BYTE_W-1:0] word;
   } sfpi_rxw_t;

   sfpi_rise_t rise_reg;
   sfpi_rise_t rise_next;
   sfpi_rxw_t rxw_reg;
   sfpi_rxw_t rxw_next;
   logic lane0_busy;

   always_comb begin
      rise_next = rise_reg;
      rxw_next = rxw_reg;
      // (RQ11) Clock ignored while paused
      // (RQ8) Lane zero carries input only when not driven
      if (hold_n && !lane0_busy) begin
         // (RQ5) Shift in on rising edge
         rise_next.shift = {rise_reg.shift[sfpi_pkg::BYTE_W-3:0],
                            dual_lane_zero_in};
         rise_next.bit_cnt = rise_reg.bit_cnt + 1'b1;
         if (rise_reg.bit_cnt == sfpi_pkg::LAST_BIT) begin
            rxw_next.word = {rise_reg.shift, dual_lane_zero_in};
            rxw_next.tog = ~rxw_reg.tog;
         end
      end
   end

   // (RQ4) Counters held clear while deselected
   always_ff @(posedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         rise_reg <= '0;
      end else begin
         rise_reg <= rise_next;
      end
   end

   // Toggle survives frame ends so no false event appears
   always_ff @(posedge sck or posedge rst) begin
      if (rst) begin
         rxw_reg <= '0;
      end else begin
         rxw_reg <= rxw_next;
      end
   end

   // ---------------- Link, falling edge: launching ----------------
   typedef struct packed {
      logic [sfpi_pkg::BYTE_W-1:0] sh;
      logic [sfpi_pkg::CNT_W-1:0] left;
      logic active;
      logic dual;
      logic lane0;
      logic lane1;
   } sfpi_fall_t;

   typedef struct packed {
      logic req_s1;
      logic req_s2;
      logic seen;
   } sfpi_txs_t;

   sfpi_fall_t fall_reg;
   sfpi_fall_t fall_next;
   sfpi_txs_t txs_reg;
   sfpi_txs_t txs_next;
   logic [sfpi_pkg::BYTE_W-1:0] mbox_data;
   logic mbox_dual;
   logic tx_new;
   logic at_boundary;

   assign tx_new = txs_reg.req_s2 != txs_reg.seen;
   // Start only on a byte edge, then stream back to back
   assign at_boundary = (rise_reg.bit_cnt == sfpi_pkg::CNT_ZERO) ||
                        fall_reg.active;
   assign lane0_busy = fall_reg.active & fall_reg.dual;

   always_comb begin
      fall_next = fall_reg;
      txs_next = txs_reg;
      txs_next.req_s1 = clk_reg.tx_req;
      txs_next.req_s2 = txs_reg.req_s1;
      // (RQ11) Outputs frozen while paused
      if (hold_n) begin
         if (fall_reg.left != sfpi_pkg::CNT_ZERO) begin
            // (RQ6) Next bit on falling edge
            fall_next.lane1 = fall_reg.sh[sfpi_pkg::BYTE_W-1];
            fall_next.lane0 = fall_reg.sh[sfpi_pkg::BYTE_W-2];
            if (fall_reg.dual) begin
               fall_next.sh = fall_reg.sh << 2;
            end else begin
               fall_next.sh = fall_reg.sh << 1;
            end
            fall_next.left = fall_reg.left - sfpi_pkg::CNT_ONE;
         end else if (tx_new && at_boundary) begin
            txs_next.seen = txs_reg.req_s2;
            fall_next.active = 1'b1;
            fall_next.dual = mbox_dual;
            fall_next.lane1 = mbox_data[sfpi_pkg::BYTE_W-1];
            fall_next.lane0 = mbox_data[sfpi_pkg::BYTE_W-2];
            if (mbox_dual) begin
               // (RQ7) Two bits per fall in dual mode
               fall_next.sh = mbox_data << 2;
               fall_next.left = sfpi_pkg::DUAL_LEFT;
            end else begin
               fall_next.sh = mbox_data << 1;
               fall_next.left = sfpi_pkg::SINGLE_LEFT;
            end
         end else begin
            // Nothing queued: let the lanes go
            fall_next.active = 1'b0;
            fall_next.dual = 1'b0;
         end
      end
   end

   // (RQ1) Launch state cleared when deselected
   always_ff @(negedge sck or posedge frame_rst) begin
      if (frame_rst) begin
         fall_reg <= '0;
      end else begin
         fall_reg <= fall_next;
      end
   end

   always_ff @(negedge sck or posedge rst) begin
      if (rst) begin
         txs_reg <= '0;
      end else begin
         txs_reg <= txs_next;
      end
   end

   // (RQ1) Released while deselected
   // (RQ11) and while paused
   assign dual_lane_one_out = fall_reg.lane1;
   assign dual_lane_one_oe_n = ~fall_reg.active | cs_n | ~hold_n;
   // (RQ7) Lane zero turns output in dual mode
   assign dual_lane_zero_out = fall_reg.lane0;
   assign dual_lane_zero_oe_n = ~(fall_reg.active & fall_reg.dual) |
                                cs_n | ~hold_n;

   // ---------------- System clock side ----------------
   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_s3;
      logic wp_s1;
      logic wp_s2;
      logic hold_s1;
      logic hold_s2;
      logic rx_s1;
      logic rx_s2;
      logic rx_s3;
      logic ack_s1;
      logic ack_s2;
      logic [sfpi_pkg::BYTE_W-1:0] pend;
      logic pend_valid;
      logic overrun;
      logic [sfpi_pkg::BYTE_W-1:0] tx_buf;
      logic tx_dual;
      logic tx_req;
   } sfpi_clk_t;

   sfpi_clk_t clk_reg;
   sfpi_clk_t clk_next;
   logic fifo_in_ready;
   logic rx_event;
   logic frame_open;
   logic frame_close;

   assign rx_event = clk_reg.rx_s2 != clk_reg.rx_s3;
   // (RQ2) Frame edges from select transitions
   assign frame_open = clk_reg.cs_s3 & ~clk_reg.cs_s2;
   assign frame_close = ~clk_reg.cs_s3 & clk_reg.cs_s2;
   assign mbox_data = clk_reg.tx_buf;
   assign mbox_dual = clk_reg.tx_dual;
   assign tx_ready = clk_reg.tx_req == clk_reg.ack_s2;

   always_comb begin
      clk_next = clk_reg;
      clk_next.cs_s1 = cs_n;
      clk_next.cs_s2 = clk_reg.cs_s1;
      clk_next.cs_s3 = clk_reg.cs_s2;
      // (RQ10) Pulled-up pin reads as high
      clk_next.wp_s1 = wp_n;
      clk_next.wp_s2 = clk_reg.wp_s1;
      clk_next.hold_s1 = hold_n;
      clk_next.hold_s2 = clk_reg.hold_s1;
      clk_next.rx_s1 = rxw_reg.tog;
      clk_next.rx_s2 = clk_reg.rx_s1;
      clk_next.rx_s3 = clk_reg.rx_s2;
      clk_next.ack_s1 = txs_reg.seen;
      clk_next.ack_s2 = clk_reg.ack_s1;
      if (clk_reg.pend_valid && fifo_in_ready) begin
         clk_next.pend_valid = 1'b0;
      end
      // Overrun clears at frame open, but a new loss wins
      if (frame_open) begin
         clk_next.overrun = 1'b0;
      end
      if (rx_event) begin
         if (clk_reg.pend_valid && !fifo_in_ready) begin
            clk_next.overrun = 1'b1;
         end else begin
            clk_next.pend = rxw_reg.word;
            clk_next.pend_valid = 1'b1;
         end
      end
      if (tx_valid && tx_ready) begin
         clk_next.tx_buf = tx_data;
         clk_next.tx_dual = tx_dual;
         clk_next.tx_req = ~clk_reg.tx_req;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_reg <= '0;
         // Select idles high before the first frame
         clk_reg.cs_s1 <= 1'b1;
         clk_reg.cs_s2 <= 1'b1;
         clk_reg.cs_s3 <= 1'b1;
         clk_reg.wp_s1 <= 1'b1;
         clk_reg.wp_s2 <= 1'b1;
         clk_reg.hold_s1 <= 1'b1;
         clk_reg.hold_s2 <= 1'b1;
      end else begin
         clk_reg <= clk_next;
      end
   end

   // Host cannot be stalled; the pending word absorbs one FIFO stall
   sfpi_fifo #(
      .WIDTH(sfpi_pkg::BYTE_W),
      .DEPTH(sfpi_pkg::FIFO_DEPTH)
   ) u_rx_fifo (
      .clk(clk),
      .rst(rst),
      .in_data(clk_reg.pend),
      .in_valid(clk_reg.pend_valid),
      .in_ready(fifo_in_ready),
      .out_data(rx_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready)
   );

   assign rx_overrun = clk_reg.overrun;
   assign selected = ~clk_reg.cs_s2;
   // (RQ3) Standby waits for the timed cycle
   // (RQ11) Pause has no say in busy
   assign standby = clk_reg.cs_s2 & ~busy;
   assign paused = ~clk_reg.hold_s2 & ~clk_reg.cs_s2;
   // (RQ9) Write protect low locks regions while prot_armed is high
   assign hw_lock = ~clk_reg.wp_s2 & prot_armed;
   assign frame_start = frame_open;
   assign frame_end = frame_close;
endmodule : sfpi_core

// *** logic/sfpi_fifo.sv ***
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module sfpi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // System
   input wire logic clk,
   input wire logic rst,
   // Fill side
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   // Drain side
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0] wr_ptr;
      logic [AW:0] rd_ptr;
   } sfpi_fifo_st_t;

   sfpi_fifo_st_t st_reg;
   sfpi_fifo_st_t st_next;
   logic full;
   logic empty;

   // Extra pointer bit tells full from empty
   assign empty = st_reg.wr_ptr == st_reg.rd_ptr;
   assign full = (st_reg.wr_ptr[AW-1:0] == st_reg.rd_ptr[AW-1:0]) &&
                 (st_reg.wr_ptr[AW] != st_reg.rd_ptr[AW]);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = st_reg.mem[st_reg.rd_ptr[AW-1:0]];

   always_comb begin
      st_next = st_reg;
      if (in_valid && !full) begin
         st_next.mem[st_reg.wr_ptr[AW-1:0]] = in_data;
         st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
         st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : sfpi_fifo

// *** logic/sfpi_pkg.sv ***
// Constants shared by the serial flash pin interface front end
// Function
// (RQ1) Deselected: standby, output lanes released
// (RQ2) Frames open on select fall, close on rise
// (RQ3) Standby waits for internal timed cycle
// (RQ4) Input line ignored while deselected
// (RQ5) Input bits sampled on clock rise
// (RQ6) Read bits launched on clock fall
// (RQ7) Dual read: both lanes drive each fall
// (RQ8) Commands and addresses on lane zero only
// (RQ9) Write protect low engages hardware locking
// (RQ10) Unconnected write protect reads as high
// (RQ11) Pause ignores clock, floats outputs
// (RQ12) Host keeps select low whole sequence
package sfpi_pkg;
   localparam int BYTE_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int CNT_W = 3;
   // Falling edges still to launch after the loading edge (bits single, bit pairs dual)
   localparam logic [2:0] SINGLE_LEFT = 3'h7;
   localparam logic [2:0] DUAL_LEFT = 3'h3;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [2:0] CNT_ZERO = 3'h0;
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam logic [2:0] CNT_TWO = 3'h2;
endpackage : sfpi_pkg
